//--- fsw_pkg.sv
// Constants, opcodes and command classes of the flash status and write-latch block
// What this block does
// - A register read keeps repeating the same register byte until chip select rises.
// - Status bit 0 is the read-only busy flag, 1 while an internal write runs.
// - Status bit 1 shows the write latch, cleared by default.
// - Status bits 2 to 5 hold the four-bit block-protect level, zero protects nothing.
// - Status bit 6 is the quad enable bit, default cleared.
// - Status bit 7 is the status lock bit, default cleared.
// - Protect, quad enable and lock bits start cleared from the factory.
// - The status write data never sets the write latch; the latch clears when the write ends.
// - Status write 01h updates protect, quad enable and lock bits.
// - Busy is set during program, erase, non-volatile register write and gang lock operations.
// - While busy only register reads, resets and the suspend below are taken, all else ignored.
// - During busy program or erase the suspend instruction is also taken.
// - When an operation ends busy clears and new instructions are taken.
// - With the latch clear, every latch-guarded write is inhibited.
// - Instruction 06h sets the write latch; hosts send it before writes.
// - The latch-clear instruction clears the write latch.
// - Completion of any non-volatile write, program or erase clears the latch.
// - Page program instructions in all forms need the latch set first.
// - Sector, block and full-array erase instructions need the latch set first.
// - Function, read-parameter and bank register writes need the latch set first.
// - Protection-related instructions need the latch set first.
// - Information row, learning-pattern and ECC register writes need the latch.
// - Codes C0h and 17h execute without a preceding latch set.
// - Lock set with protect pin low makes status writes ignored, unless quad enable is set.
// - Full-array erase is ignored unless the protect level is zero.
package fsw_pkg;

	// ==========================================================
	// Status byte layout
	localparam int             ST_BUSY_BIT  = 0;
	localparam int             ST_LATCH_BIT = 1;
	localparam int             ST_PROT_LSB  = 2;
	localparam int             ST_PROT_MSB  = 5;
	localparam int             ST_QUAD_BIT  = 6;
	localparam int             ST_LOCK_BIT  = 7;
	localparam logic [7:0]     STATUS_RESET = 8'h00;
	localparam logic [3:0]     PROT_RESET   = 4'h0;

	// ==========================================================
	// Pin synchroniser: csN, sck, si, wpN, hwResetN (bit 0 first)
	localparam int             PIN_COUNT    = 5;
	localparam logic [4:0]     PIN_IDLE     = 5'h19;

	// ==========================================================
	// Timing
	localparam int             CLK_PERIOD_NS = 40;
	localparam int             OP_TIME_NS    = 100000;
	localparam int             OP_CYCLES     = OP_TIME_NS / CLK_PERIOD_NS;
	localparam int             OP_CNT_W      = 12;

	// ==========================================================
	// Opcodes handled directly
	localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
	localparam logic [7:0] OP_LATCH_CLEAR   = 8'h04;
	localparam logic [7:0] OP_STATUS_READ   = 8'h05;
	localparam logic [7:0] OP_LATCH_SET     = 8'h06;
	localparam logic [7:0] OP_FUNC_READ     = 8'h48;
	localparam logic [7:0] OP_XPARAM_READ   = 8'h81;
	localparam logic [7:0] OP_RESET_ARM     = 8'h66;
	localparam logic [7:0] OP_RESET_GO      = 8'h99;
	localparam logic [7:0] OP_SUSPEND       = 8'h75;
	localparam logic [7:0] OP_SUSPEND_ALT   = 8'hB0;
	localparam logic [7:0] OP_RESUME        = 8'h7A;
	localparam logic [7:0] OP_RESUME_ALT    = 8'h30;
	localparam logic [7:0] OP_ERASE_ALL     = 8'hC7;
	localparam logic [7:0] OP_ERASE_ALL_ALT = 8'h60;
	localparam logic [7:0] OP_VOL_PARAM_ALT = 8'hC0;
	localparam logic [7:0] OP_VOL_BANK_ALT  = 8'h17;
	localparam logic [4:0] BITS_OPCODE      = 5'h08;
	localparam logic [4:0] BITS_WITH_DATA   = 5'h10;

	// ==========================================================
	// Command classes
	typedef enum logic [2:0] {
		CL_OTHER    = 3'h0,
		CL_PROGERA  = 3'h1,
		CL_NVWRITE  = 3'h2,
		CL_VOLATILE = 3'h3,
		CL_FREE     = 3'h4
	} fsw_class_t;

	// Operation sequencer states
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_BUSY = 3'b010,
		S_SUSP = 3'b100
	} fsw_state_t;

	function automatic fsw_class_t fsw_classify(input logic [7:0] op);
		fsw_class_t c;
		c = CL_OTHER;
		unique case (op)
			8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E,
			8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60:
				c = CL_PROGERA;
			8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h18, 8'hFD, 8'hE3,
			8'hE4, 8'h2F, 8'hA6, 8'h7E, 8'h98, 8'hE8, 8'h43, 8'hB5:
				c = CL_NVWRITE;
			// volatile writes guarded by the latch
			8'h63, 8'h83, 8'hC5, 8'hFB, 8'hE1, 8'h91, 8'h4A:
				c = CL_VOLATILE;
			// alternate volatile codes, no latch needed
			8'hC0, 8'h17:
				c = CL_FREE;
			default:
				c = CL_OTHER;
		endcase
		return c;
	endfunction

endpackage

//--- fsw_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/10ps
module fsw_pin_sync #(
	parameter int                WIDTH    = 1,
	parameter logic [WIDTH-1:0]  IDLE_VAL = '0
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [WIDTH-1:0]  pinIn,
	output logic      [WIDTH-1:0]  pinOut
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;
	logic [WIDTH-1:0] agree;
	logic [WIDTH-1:0] pinOut_nxt;

	// Only the second and third stages are compared; the first may be metastable
	assign agree      = ~(stage2_r ^ stage3_r);
	assign pinOut_nxt = (agree & stage3_r) | (~agree & pinOut);

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			stage1_r <= IDLE_VAL;
			stage2_r <= IDLE_VAL;
			stage3_r <= IDLE_VAL;
			pinOut   <= IDLE_VAL;
		end
		else
		begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			pinOut   <= pinOut_nxt;
		end
	end

endmodule // fsw_pin_sync

//--- fsw_op_timer.sv
// Duration counter for internal write cycles, with hold and abort
`timescale 1ns/10ps
module fsw_op_timer (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic hold,
	input  wire logic abort,
	output logic      done
);

	localparam logic [fsw_pkg::OP_CNT_W-1:0] LOAD =
		fsw_pkg::OP_CNT_W'(fsw_pkg::OP_CYCLES - 1);

	logic [fsw_pkg::OP_CNT_W-1:0] count_r;
	logic                         run_r;
	logic                         finish;

	assign finish = run_r & ~hold & ~abort & (count_r == '0);

	always_ff @(posedge clock)
	begin
		if (rst | abort)
		begin
			count_r <= '0;
			run_r   <= 1'b0;
			done    <= 1'b0;
		end
		else if (start)
		begin
			count_r <= LOAD;
			run_r   <= 1'b1;
			done    <= 1'b0;
		end
		else
		begin
			done <= finish;
			if (finish)
				run_r <= 1'b0;
			else if (run_r & ~hold)
				count_r <= count_r - 1'b1;
		end
	end

endmodule // fsw_op_timer

//--- fsw_status_core.sv
// Serial flash status byte, write latch and busy sequencer behind the SPI pins
`timescale 1ns/10ps
module fsw_status_core (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       csN,
	input  wire logic       sck,
	input  wire logic       si,
	input  wire logic       wpN,
	input  wire logic       hwResetN,
	output logic            so,
	output logic            soEn,
	output logic            opRunning,
	output logic            writeLatch,
	output logic [3:0]      protectLevel,
	output logic            quadIoEnable,
	output logic            statusLock
);

	// ==========================================================
	// Pin synchronisation and edges
	logic [4:0] pinRaw;
	logic [4:0] pinSync;
	logic       csNS;
	logic       sckS;
	logic       siS;
	logic       wpNS;
	logic       hwResetNS;
	logic       csPrev_r;
	logic       sckPrev_r;
	logic       sckRise;
	logic       sckFall;
	logic       frameEnd;

	assign pinRaw = {hwResetN, wpN, si, sck, csN};

	fsw_pin_sync #(
		.WIDTH    (fsw_pkg::PIN_COUNT),
		.IDLE_VAL (fsw_pkg::PIN_IDLE)
	) u_sync (
		.clock  (clock),
		.rst    (rst),
		.pinIn  (pinRaw),
		.pinOut (pinSync)
	);

	assign csNS      = pinSync[0];
	assign sckS      = pinSync[1];
	assign siS       = pinSync[2];
	assign wpNS      = pinSync[3];
	assign hwResetNS = pinSync[4];
	assign sckRise   = ~csNS & sckS & ~sckPrev_r;
	assign sckFall   = ~csNS & ~sckS & sckPrev_r;
	assign frameEnd  = csNS & ~csPrev_r;

	// ==========================================================
	// Serial input shifter
	logic [7:0] shiftIn_r;
	logic [7:0] shiftIn_nxt;
	logic [4:0] bitCount_r;
	logic [4:0] bitCount_nxt;
	logic [7:0] opcode_r;
	logic [7:0] dataByte_r;
	logic       opcodeDone;
	logic       dataDone;

	assign shiftIn_nxt  = {shiftIn_r[6:0], siS};
	assign opcodeDone   = sckRise & (bitCount_r == fsw_pkg::BITS_OPCODE - 5'h01);
	assign dataDone     = sckRise & (bitCount_r == fsw_pkg::BITS_WITH_DATA - 5'h01);
	// Count saturates so long address or data phases never wrap into a fake opcode
	assign bitCount_nxt = (bitCount_r == 5'h1F) ? bitCount_r : bitCount_r + 5'h01;

	always_ff @(posedge clock)
	begin
		if (rst | csNS)
		begin
			shiftIn_r  <= 8'h00;
			bitCount_r <= 5'h00;
		end
		else if (sckRise)
		begin
			shiftIn_r  <= shiftIn_nxt;
			bitCount_r <= bitCount_nxt;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			opcode_r   <= 8'h00;
			dataByte_r <= 8'h00;
			csPrev_r   <= 1'b1;
			sckPrev_r  <= 1'b0;
		end
		else
		begin
			csPrev_r  <= csNS;
			sckPrev_r <= sckS;
			if (opcodeDone)
				opcode_r <= shiftIn_nxt;
			if (dataDone)
				dataByte_r <= shiftIn_nxt;
		end
	end

	// ==========================================================
	// Status byte
	logic                   latch_r;
	logic                   latch_nxt;
	logic [3:0]             prot_r;
	logic                   quad_r;
	logic                   lock_r;
	fsw_pkg::fsw_state_t    state_r;
	fsw_pkg::fsw_state_t    state_nxt;
	logic                   busy;
	logic [7:0]             statusByte;

	// busy only while the sequencer runs an operation
	assign busy = (state_r == fsw_pkg::S_BUSY);

	always_comb
	begin
		statusByte                                         = fsw_pkg::STATUS_RESET;
		statusByte[fsw_pkg::ST_BUSY_BIT]                   = busy;
		statusByte[fsw_pkg::ST_LATCH_BIT]                  = latch_r;
		statusByte[fsw_pkg::ST_PROT_MSB:fsw_pkg::ST_PROT_LSB] = prot_r;
		statusByte[fsw_pkg::ST_QUAD_BIT]                   = quad_r;
		statusByte[fsw_pkg::ST_LOCK_BIT]                   = lock_r;
	end

	// ==========================================================
	// Serial output: register reads repeat until chip select rises
	logic       readStatus;
	logic       readZero;
	logic       readActive_r;
	logic [7:0] shiftOut_r;
	logic [2:0] outCount_r;
	logic [7:0] readSource;

	assign readStatus = (shiftIn_nxt == fsw_pkg::OP_STATUS_READ);
	assign readZero   = (shiftIn_nxt == fsw_pkg::OP_FUNC_READ) |
	                    (shiftIn_nxt == fsw_pkg::OP_XPARAM_READ);
	// Registers other than status are outside this block and read as zero
	assign readSource = (opcode_r == fsw_pkg::OP_STATUS_READ) ? statusByte : 8'h00;

	always_ff @(posedge clock)
	begin
		if (rst | csNS)
		begin
			readActive_r <= 1'b0;
			outCount_r   <= 3'h0;
			shiftOut_r   <= 8'h00;
			so           <= 1'b0;
			soEn         <= 1'b0;
		end
		else
		begin
			if (opcodeDone)
				readActive_r <= readStatus | readZero;
			// reload the live byte at each byte boundary
			if (sckFall & readActive_r)
			begin
				soEn       <= 1'b1;
				outCount_r <= outCount_r + 3'h1;
				if (outCount_r == 3'h0)
				begin
					so         <= readSource[7];
					shiftOut_r <= {readSource[6:0], 1'b0};
				end
				else
				begin
					so         <= shiftOut_r[7];
					shiftOut_r <= {shiftOut_r[6:0], 1'b0};
				end
			end
		end
	end

	// ==========================================================
	// Instruction decode at the end of each frame
	fsw_pkg::fsw_class_t opClass;
	logic                full;
	logic                allowedBusy;
	logic                accepted;
	logic                isSuspend;
	logic                isResume;
	logic                softReset;
	logic                hardReset;
	logic                wpLow;
	logic                statusLocked;
	logic                eraseAllBlocked;
	logic                guarded;
	logic                startOp;
	logic                statusWrite;
	logic                doSuspend;
	logic                doResume;
	logic                opDone;
	logic                progEraseOp_r;
	logic                resetArmed_r;

	assign opClass   = fsw_pkg::fsw_classify(opcode_r);
	assign full      = (bitCount_r >= fsw_pkg::BITS_OPCODE);
	assign isSuspend = (opcode_r == fsw_pkg::OP_SUSPEND) |
	                   (opcode_r == fsw_pkg::OP_SUSPEND_ALT);
	assign isResume  = (opcode_r == fsw_pkg::OP_RESUME) |
	                   (opcode_r == fsw_pkg::OP_RESUME_ALT);

	// only reads, resets and, during program or erase, suspend pass while busy
	assign allowedBusy = (opcode_r == fsw_pkg::OP_STATUS_READ) |
	                     (opcode_r == fsw_pkg::OP_FUNC_READ) |
	                     (opcode_r == fsw_pkg::OP_XPARAM_READ) |
	                     (opcode_r == fsw_pkg::OP_RESET_ARM) |
	                     (opcode_r == fsw_pkg::OP_RESET_GO) |
	                     (isSuspend & progEraseOp_r);
	assign accepted    = frameEnd & full & (~busy | allowedBusy);

	assign softReset = accepted & resetArmed_r & (opcode_r == fsw_pkg::OP_RESET_GO);
	// The reset pin shares a ball with a quad data line, so quad mode disables it
	assign hardReset = ~hwResetNS & ~quad_r;
	// Protect pin likewise doubles as a quad data line
	assign wpLow     = ~wpNS & ~quad_r;

	assign statusLocked    = lock_r & wpLow;
	// array erase only with no block protected
	assign eraseAllBlocked = ((opcode_r == fsw_pkg::OP_ERASE_ALL) |
	                          (opcode_r == fsw_pkg::OP_ERASE_ALL_ALT)) & (prot_r != 4'h0);
	assign guarded = accepted & latch_r & (state_r == fsw_pkg::S_IDLE);

	// long operations run the busy sequencer
	assign statusWrite = guarded & (opcode_r == fsw_pkg::OP_STATUS_WRITE) & ~statusLocked &
	                     (bitCount_r >= fsw_pkg::BITS_WITH_DATA);
	assign startOp     = statusWrite |
	                     (guarded & (opClass == fsw_pkg::CL_PROGERA) & ~eraseAllBlocked) |
	                     (guarded & (opClass == fsw_pkg::CL_NVWRITE) &
	                      (opcode_r != fsw_pkg::OP_STATUS_WRITE));
	assign doSuspend   = accepted & busy & isSuspend & progEraseOp_r;
	assign doResume    = accepted & (state_r == fsw_pkg::S_SUSP) & isResume;

	fsw_op_timer u_timer (
		.clock (clock),
		.rst   (rst),
		.start (startOp),
		.hold  (state_r == fsw_pkg::S_SUSP),
		.abort (softReset | hardReset),
		.done  (opDone)
	);

	// ==========================================================
	// Operation sequencer
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			fsw_pkg::S_IDLE:
				if (startOp)
					state_nxt = fsw_pkg::S_BUSY;
			fsw_pkg::S_BUSY:
				if (opDone)
					state_nxt = fsw_pkg::S_IDLE;
				else if (doSuspend)
					state_nxt = fsw_pkg::S_SUSP;
			fsw_pkg::S_SUSP:
				if (doResume)
					state_nxt = fsw_pkg::S_BUSY;
			default:
				state_nxt = fsw_pkg::S_IDLE;
		endcase
		if (softReset | hardReset)
			state_nxt = fsw_pkg::S_IDLE;
	end

	// ==========================================================
	// Write latch
	always_comb
	begin
		latch_nxt = latch_r;
		// cleared when a non-volatile write, program or erase ends
		if (opDone)
			latch_nxt = 1'b0;
		if (accepted & (opcode_r == fsw_pkg::OP_LATCH_CLEAR))
			latch_nxt = 1'b0;
		if (softReset | hardReset)
			latch_nxt = 1'b0;
		// set is applied last so it wins
		if (accepted & ~busy & (opcode_r == fsw_pkg::OP_LATCH_SET))
			latch_nxt = 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			// busy and latch clear from reset
			state_r       <= fsw_pkg::S_IDLE;
			latch_r       <= 1'b0;
			progEraseOp_r <= 1'b0;
			resetArmed_r  <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			// latch moves only by its own logic
			latch_r <= latch_nxt;
			if (startOp)
				progEraseOp_r <= (opClass == fsw_pkg::CL_PROGERA);
			if (accepted)
				resetArmed_r <= (opcode_r == fsw_pkg::OP_RESET_ARM);
		end
	end

	// ==========================================================
	// Non-volatile status bits
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prot_r <= fsw_pkg::PROT_RESET;
			quad_r <= 1'b0;
			lock_r <= 1'b0;
		end
		// status write takes bits 7 to 2
		else if (statusWrite)
		begin
			prot_r <= dataByte_r[fsw_pkg::ST_PROT_MSB:fsw_pkg::ST_PROT_LSB];
			quad_r <= dataByte_r[fsw_pkg::ST_QUAD_BIT];
			lock_r <= dataByte_r[fsw_pkg::ST_LOCK_BIT];
		end
	end

	// ==========================================================
	// Status outputs, registered copies
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			opRunning    <= 1'b0;
			writeLatch   <= 1'b0;
			protectLevel <= fsw_pkg::PROT_RESET;
			quadIoEnable <= 1'b0;
			statusLock   <= 1'b0;
		end
		else
		begin
			opRunning    <= (state_nxt == fsw_pkg::S_BUSY);
			writeLatch   <= latch_nxt;
			protectLevel <= prot_r;
			quadIoEnable <= quad_r;
			statusLock   <= lock_r;
		end
	end

endmodule // fsw_status_core

//--- fsw_status_core_props.sv
// Concurrent checks on the status byte and write latch ports
`timescale 1ns/10ps
module fsw_status_core_props (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       csN,
	input wire logic       sck,
	input wire logic       si,
	input wire logic       wpN,
	input wire logic       hwResetN,
	input wire logic       so,
	input wire logic       soEn,
	input wire logic       opRunning,
	input wire logic       writeLatch,
	input wire logic [3:0] protectLevel,
	input wire logic       quadIoEnable,
	input wire logic       statusLock
);
	logic [11:0] busyCnt_r;
	logic [3:0]  wpLowCnt_r;
	wire  [5:0]  nvBits = {statusLock, quadIoEnable, protectLevel};
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ====================
	// Helper counters
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			busyCnt_r <= 12'h000;
			wpLowCnt_r <= 4'h0;
		end
		else
		begin
			busyCnt_r <= opRunning ? busyCnt_r + 12'h001 : 12'h000;
			wpLowCnt_r <= wpN ? 4'h0 : wpLowCnt_r + {3'h0, wpLowCnt_r != 4'h8};
		end
	end
	// ====================
	// Properties
	// reset clears all
	a_reset_clears_all: assert property (disable iff (1'b0)
		rst |=> {nvBits, opRunning, writeLatch, soEn} == 9'h000)
		else $error("outputs not cleared by reset");
	a_busy_needs_latch: assert property ($rose(opRunning) |-> writeLatch)
		else $error("operation started without write latch");
	a_busy_bounded: assert property (busyCnt_r <= 12'(fsw_pkg::OP_CYCLES + 1))
		else $error("busy flag held too long");
	a_latch_clears_end: assert property ($fell(opRunning)
		&& busyCnt_r >= 12'(fsw_pkg::OP_CYCLES - 1) |-> !writeLatch)
		else $error("latch survived operation end");
	a_latch_held_busy: assert property (opRunning && hwResetN
		&& $past(hwResetN, 6) |-> writeLatch)
		else $error("latch lost during operation");
	a_nv_change_busy: assert property ($changed(nvBits) |-> ##[0:2] opRunning)
		else $error("status bits changed outside a write");
	a_lock_freezes_bits: assert property (statusLock && !quadIoEnable
		&& wpLowCnt_r == 4'h8 |=> $stable(nvBits))
		else $error("locked status bits changed");
	a_soen_off_idle: assert property (csN [*8] |-> !soEn)
		else $error("output enabled while deselected");
	a_soen_in_frame: assert property ($rose(soEn) |-> !csN && $past(csN, 8) == 1'b0)
		else $error("output enabled before opcode shifted");
	a_latch_rise_idle: assert property ($rose(writeLatch) |-> !opRunning && $past(csN, 2))
		else $error("latch set while busy or mid frame");
endmodule // fsw_status_core_props

bind fsw_status_core fsw_status_core_props u_fsw_status_core_props (
	.clock(clock), .rst(rst), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
	.hwResetN(hwResetN), .so(so), .soEn(soEn), .opRunning(opRunning),
	.writeLatch(writeLatch), .protectLevel(protectLevel),
	.quadIoEnable(quadIoEnable), .statusLock(statusLock)
);

//--- fsw_spi_host.sv
// SPI mode 0 host model that shifts frames into the status block
`timescale 1ns/10ps
module fsw_spi_host (
	input  wire logic       clock,
	input  wire logic       so,
	input  wire logic       soEn,
	output logic            csN,
	output logic            sck,
	output logic            si,
	output logic [7:0]      rdByte,
	output logic            rdStrobe
);
	// ====================
	// Idle: clock parked low, data shows inverse of last bit
	initial
	begin
		csN = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rdByte = 8'h00;
		rdStrobe = 1'b0;
	end
	always @(posedge clock)
		if (rdStrobe)
			#1 rdStrobe = 1'b0;
	// ====================
	// Frame: sample late in the high phase, sync delay makes early samples unsafe
	task automatic frame(input logic [7:0] tx[$], input int nRead);
		logic [7:0] sh;
		int i;
		int b;
		@(posedge clock);
		#1 csN = 1'b0;
		for (i = 0; i < tx.size() + nRead; i++)
		begin
			sh = (i < tx.size()) ? tx[i] : 8'h00;
			for (b = 7; b >= 0; b--)
			begin
				si = (i < tx.size()) ? sh[b] : ~si;
				repeat (4) @(posedge clock);
				#1 sck = 1'b1;
				repeat (4) @(posedge clock);
				sh[b] = soEn ? so : 1'bx;
				#1 sck = 1'b0;
			end
			if (i >= tx.size())
			begin
				rdByte = sh;
				rdStrobe = 1'b1;
			end
		end
		si = ~si;
		repeat (4) @(posedge clock);
		#1 csN = 1'b1;
		repeat (8) @(posedge clock);
	endtask
endmodule // fsw_spi_host

//--- test_flash_status_write_enable.sv
// Self-checking bench for the status byte and write latch
`timescale 1ns/10ps
module test_flash_status_write_enable;
	logic        clock;
	logic        rst;
	logic        csN;
	logic        sck;
	logic        si;
	logic        wpN;
	logic        hwResetN;
	logic        so;
	logic        soEn;
	logic        opRunning;
	logic        writeLatch;
	logic [3:0]  protectLevel;
	logic        quadIoEnable;
	logic        statusLock;
	logic [7:0]  rdByte;
	logic        rdStrobe;
	logic [7:0]  expQ[$];
	logic [7:0]  expV;
	logic [7:0]  d;
	wire  [7:0]  portByte = {statusLock, quadIoEnable, protectLevel, writeLatch, opRunning};
	logic [15:0] lfsr;
	logic [7:0]  codes[6] = '{8'h02, 8'h20, 8'h42, 8'hE4, 8'h64, 8'h4A};
	int          nErrors = 0;
	int          samplesChecked = 0;
	int          i;
	fsw_status_core u_fsw_status_core (
		.clock(clock), .rst(rst), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
		.hwResetN(hwResetN), .so(so), .soEn(soEn), .opRunning(opRunning),
		.writeLatch(writeLatch), .protectLevel(protectLevel),
		.quadIoEnable(quadIoEnable), .statusLock(statusLock)
	);
	fsw_spi_host u_fsw_spi_host (
		.clock(clock), .so(so), .soEn(soEn), .csN(csN), .sck(sck), .si(si),
		.rdByte(rdByte), .rdStrobe(rdStrobe)
	);
	always #20 clock = ~clock;
	// ====================
	// Helpers
	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic send(input logic [7:0] tx[$]);
		u_fsw_spi_host.frame(tx, 0);
	endtask
	task automatic readStatus(input logic [7:0] e, input int n);
		repeat (n) expQ.push_back(e);
		u_fsw_spi_host.frame({fsw_pkg::OP_STATUS_READ}, n);
	endtask
	task automatic waitIdle();
		int k;
		for (k = 0; k < 3000 && opRunning !== 1'b0; k++)
			@(posedge clock);
		if (k == 3000)
		begin
			nErrors++;
			$display("CHECK FAILED at %0t: busy flag never cleared", $time);
		end
		repeat (8) @(posedge clock);
	endtask
	task automatic endTest(input string name);
		$display("test %0s done, mismatches so far %0d", name, nErrors);
	endtask
	task automatic results();
		if (expQ.size() != 0)
			nErrors++;
		$display("compared %0d, mismatched %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ====================
	// Monitor
	always @(posedge clock)
		if (rdStrobe === 1'b1)
		begin
			samplesChecked++;
			expV = expQ.size() ? expQ.pop_front() : 8'hxx;
			if (rdByte !== expV)
			begin
				nErrors++;
				$display("CHECK FAILED at %0t: read %h expected %h", $time, rdByte, expV);
			end
			// Port copies settle long before a read frame ends
			if (portByte !== expV)
			begin
				nErrors++;
				$display("CHECK FAILED at %0t: ports %h expected %h", $time, portByte, expV);
			end
		end
	// ====================
	// Watchdog, about twice the expected run
	initial
	begin
		repeat (100000) @(posedge clock);
		nErrors++;
		$display("CHECK FAILED at %0t: run timed out", $time);
		results();
	end
	// ====================
	// Main sequence
	initial
	begin
		clock = 1'b0;
		rst = 1'b1;
		wpN = 1'b1;
		hwResetN = 1'b1;
		lfsr = 16'h0002;
		repeat (4) @(posedge clock);
		#1 rst = 1'b0;
		repeat (8) @(posedge clock);
		readStatus(8'h00, 3);
		endTest("reset");
		for (i = 0; i < 6; i++)
		begin
			lfsr = lfsrNext(lfsr);
			send({codes[i], lfsr[15:8], lfsr[7:0], 8'h00});
			readStatus(8'h00, 1);
			send({fsw_pkg::OP_LATCH_SET});
			readStatus(8'h02, 1);
			send({codes[i], lfsr[15:8], lfsr[7:0], 8'h00});
			readStatus(i < 5 ? 8'h03 : 8'h02, 1);
			waitIdle();
			readStatus(i < 5 ? 8'h00 : 8'h02, 1);
			send({fsw_pkg::OP_LATCH_CLEAR});
			readStatus(8'h00, 1);
		end
		endTest("guarded");
		lfsr = lfsrNext(lfsr);
		d = (lfsr[7:0] & 8'h3C) | 8'h07;
		send({fsw_pkg::OP_LATCH_SET});
		send({fsw_pkg::OP_STATUS_WRITE, d});
		readStatus(d, 1);
		send({fsw_pkg::OP_SUSPEND});
		send({fsw_pkg::OP_LATCH_CLEAR});
		readStatus(d, 1);
		waitIdle();
		readStatus(d & 8'hFC, 1);
		send({fsw_pkg::OP_LATCH_SET});
		send({fsw_pkg::OP_ERASE_ALL});
		readStatus((d & 8'hFC) | 8'h02, 1);
		send({fsw_pkg::OP_STATUS_WRITE, 8'h00});
		waitIdle();
		send({fsw_pkg::OP_LATCH_SET});
		send({fsw_pkg::OP_ERASE_ALL_ALT});
		readStatus(8'h03, 1);
		waitIdle();
		readStatus(8'h00, 1);
		endTest("status write");
		send({fsw_pkg::OP_LATCH_SET});
		send({8'h02, 8'h00, 8'h10, 8'h00});
		send({fsw_pkg::OP_SUSPEND});
		readStatus(8'h02, 1);
		send({fsw_pkg::OP_RESUME});
		readStatus(8'h03, 1);
		waitIdle();
		readStatus(8'h00, 1);
		endTest("suspend");
		send({fsw_pkg::OP_LATCH_SET});
		send({fsw_pkg::OP_STATUS_WRITE, 8'h08});
		#1 hwResetN = 1'b0;
		repeat (10) @(posedge clock);
		#1 hwResetN = 1'b1;
		readStatus(8'h08, 1);
		send({fsw_pkg::OP_LATCH_SET});
		send({fsw_pkg::OP_STATUS_WRITE, 8'h80});
		waitIdle();
		#1 wpN = 1'b0;
		send({fsw_pkg::OP_LATCH_SET});
		send({fsw_pkg::OP_STATUS_WRITE, 8'h00});
		readStatus(8'h82, 1);
		#1 wpN = 1'b1;
		send({fsw_pkg::OP_STATUS_WRITE, 8'h00});
		readStatus(8'h03, 1);
		waitIdle();
		readStatus(8'h00, 1);
		endTest("lock");
		// quad mode masks the reset pin, software reset still aborts
		send({fsw_pkg::OP_LATCH_SET});
		send({fsw_pkg::OP_STATUS_WRITE, 8'h40});
		waitIdle();
		send({fsw_pkg::OP_LATCH_SET});
		send({8'h02, lfsr[15:8], lfsr[7:0], 8'h00});
		#1 hwResetN = 1'b0;
		repeat (10) @(posedge clock);
		#1 hwResetN = 1'b1;
		readStatus(8'h43, 1);
		send({fsw_pkg::OP_RESET_ARM});
		send({fsw_pkg::OP_RESET_GO});
		readStatus(8'h40, 1);
		send({fsw_pkg::OP_LATCH_SET});
		send({fsw_pkg::OP_STATUS_WRITE, 8'h00});
		waitIdle();
		readStatus(8'h00, 1);
		endTest("quad");
		results();
	end
endmodule // test_flash_status_write_enable
